// >>> inc/pof_pkg.sv
// constants and types for the pixel output and line sync front end
//
// Contract
// RQ1 - each channel byte has bit 7 as MSB
// RQ2 - fixed pixel latency from sample to output
// RQ3 - phase shifts data, clock, sync together
// RQ4 - forwarded clock strobes data and line sync
// RQ5 - forwarded clock locked to sampling clock
// RQ6 - hsync is line and frequency reference
// RQ7 - hsync sense from mode bit 6, 0x0E
// RQ8 - only leading hsync edge is used
// RQ9 - polarity 0 falling edge, 1 rising
// RQ10 - line sync regenerated, programmable polarity, width
// RQ11 - hsync synchronised, one pulse per edge
package pof_pkg;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int PIX_W = 8;
    localparam int CHAN_N = 3;
    localparam int WORD_W = PIX_W * CHAN_N;
    localparam int PHASE_W = 4;
    localparam int HSW_W = 8;
    localparam int LAT_PIX = 3;
    localparam int SYNC_STAGES = 2;
    // ------------------------------------------------------------
    // mode register location of the hsync sense bit
    // ------------------------------------------------------------
    localparam logic [7:0] MODE_REG_ADDR = 8'h0E;
    localparam int HS_POL_BIT = 6;
    // ------------------------------------------------------------
    // channel positions in the output word
    // ------------------------------------------------------------
    localparam int CH_RED_POS = 16;
    localparam int CH_GREEN_POS = 8;
    localparam int CH_BLUE_POS = 0;
    // ------------------------------------------------------------
    // configuration word and its value after reset
    // ------------------------------------------------------------
    typedef struct packed {
        logic hs_pol;
        logic out_pol;
        logic [HSW_W-1:0] width;
        logic [PHASE_W-1:0] phase;
    } pof_cfg_t;
    localparam logic HS_POL_RST = 1'h0;
    localparam logic OUT_POL_RST = 1'h1;
    localparam logic [HSW_W-1:0] HSW_RST = 8'h20;
    localparam logic [PHASE_W-1:0] PHASE_RST = 4'h0;
    localparam pof_cfg_t CFG_RST = '{HS_POL_RST, OUT_POL_RST, HSW_RST, PHASE_RST};
    // ------------------------------------------------------------
    // line sync pulse states
    // ------------------------------------------------------------
    typedef enum logic [0:0] {HS_IDLE, HS_PULSE} pof_hs_state_t;
endpackage

// >>> inc/pof_hs_if.sv
// hsync edge events passed from the detector to the front end
`timescale 1ns/1ps
`default_nettype none
interface pof_hs_if;
    logic pol;
    logic lead;
    modport det (input pol, output lead);
    modport sink (output pol, input lead);
endinterface
`default_nettype wire

// >>> core/pof_hs_edge.sv
// hsync pin synchroniser and leading edge detector
`timescale 1ns/1ps
`default_nettype none
module pof_hs_edge (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic hsync_i,
    pof_hs_if.det hs
);
    import pof_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
        logic lead;
    } pof_edge_t;

    pof_edge_t q;
    pof_edge_t next_q;

    // two stage sync, then one pulse per active edge
    always_comb begin
        next_q = q;
        if (srst_i) begin
            next_q = '0;
        end else if (ce_i) begin
            next_q.s1 = hsync_i; // RQ11
            next_q.s2 = q.s1;
            next_q.prev = q.s2;
            // trailing edge never produces an event
            if (hs.pol) begin
                next_q.lead = q.s2 & ~q.prev; // RQ9
            end else begin
                next_q.lead = ~q.s2 & q.prev; // RQ9
            end
        end
    end

    always_ff @(posedge clk_i) begin
        q <= next_q;
    end

    assign hs.lead = q.lead; // RQ8
endmodule
`default_nettype wire

// >>> core/pof_shift.sv
// selectable delay line shared by data, clock and sync
`timescale 1ns/1ps
`default_nettype none
module pof_shift #(
    parameter int W = 26,
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic [$clog2(DEPTH)-1:0] sel_i,
    input wire logic [W-1:0] din_i,
    output logic [W-1:0] dout_o
);
    import pof_pkg::*;

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] line;
        logic [W-1:0] dout;
    } pof_line_t;

    pof_line_t q;
    pof_line_t next_q;

    // every bit takes the same tap, so relative timing holds
    always_comb begin
        next_q = q;
        if (srst_i) begin
            next_q = '0;
        end else if (ce_i) begin
            next_q.line[0] = din_i;
            for (int i = 1; i < DEPTH; i++) begin
                next_q.line[i] = q.line[i-1];
            end
            next_q.dout = q.line[sel_i]; // RQ3
        end
    end

    always_ff @(posedge clk_i) begin
        q <= next_q;
    end

    assign dout_o = q.dout;
endmodule
`default_nettype wire

// >>> core/pof_front.sv
// pixel output stage, forwarded clock and regenerated line sync
`timescale 1ns/1ps
`default_nettype none
module pof_front #(
    parameter int LEN_W = 12
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic cfg_load_i,
    input wire pof_pkg::pof_cfg_t cfg_i,
    output logic cfg_busy_o,
    input wire logic pix_clk_i,
    input wire logic [pof_pkg::WORD_W-1:0] sample_i,
    input wire logic hsync_i,
    output logic [pof_pkg::WORD_W-1:0] data_o,
    output logic pixel_out_clock_o,
    output logic line_sync_out_o,
    output logic line_mark_o,
    output logic [LEN_W-1:0] line_len_o
);
    import pof_pkg::*;

    localparam int DEPTH = 2 ** PHASE_W;
    localparam int BUN_W = WORD_W + 2;
    localparam logic [LEN_W-1:0] LEN_MAX = '1;
    localparam logic [LEN_W-1:0] LEN_ONE = {{(LEN_W-1){1'b0}}, 1'b1};
    localparam logic [HSW_W-1:0] HSW_ONE = {{(HSW_W-1){1'b0}}, 1'b1};

    // ------------------------------------------------------------
    // system clock side: configuration hand-off
    // ------------------------------------------------------------
    typedef struct packed {
        pof_cfg_t hold;
        logic req;
        logic ack1;
        logic ack2;
    } pof_sys_t;

    // ------------------------------------------------------------
    // pixel clock side
    // ------------------------------------------------------------
    typedef struct packed {
        logic rs1;
        logic rs2;
        logic ce1;
        logic ce2;
        logic tg1;
        logic tg2;
        logic tg3;
        pof_cfg_t cfg;
        logic half;
        logic pend;
        logic [LAT_PIX-1:0][WORD_W:0] pipe;
        pof_hs_state_t st;
        logic [HSW_W-1:0] wcnt;
        logic [LEN_W-1:0] len_cnt;
        logic [LEN_W-1:0] len;
        logic mark;
    } pof_pix_t;

    pof_sys_t s;
    pof_sys_t next_s;
    pof_pix_t p;
    pof_pix_t next_p;

    pof_hs_if hs ();

    logic busy;
    logic sync_now;
    logic [BUN_W-1:0] bundle;
    logic [BUN_W-1:0] bundle_dly;

    // ------------------------------------------------------------
    // system side process
    // ------------------------------------------------------------

    // a new word is accepted only when the last one was taken
    assign busy = s.req ^ s.ack2;

    always_comb begin
        next_s = s;
        if (srst_i) begin
            next_s.hold = CFG_RST;
            next_s.req = 1'b0;
            next_s.ack1 = 1'b0;
            next_s.ack2 = 1'b0;
        end else if (ce_i) begin
            next_s.ack1 = p.tg3;
            next_s.ack2 = s.ack1;
            if (cfg_load_i && !busy) begin
                next_s.hold = cfg_i;
                next_s.req = ~s.req;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        s <= next_s;
    end

    assign cfg_busy_o = busy;

    // ------------------------------------------------------------
    // hsync edge detection on the pixel clock
    // ------------------------------------------------------------

    // sense bit taken from the captured mode word
    assign hs.pol = p.cfg.hs_pol; // RQ7

    pof_hs_edge u_edge (
        .clk_i(pix_clk_i),
        .srst_i(p.rs2),
        .ce_i(p.ce2),
        .hsync_i(hsync_i),
        .hs(hs)
    );

    // line sync level entering the data pipe
    assign sync_now = (p.st == HS_PULSE) ~^ p.cfg.out_pol; // RQ10

    // ------------------------------------------------------------
    // pixel side process
    // ------------------------------------------------------------

    // reset and enable arrive through two stage synchronisers
    always_comb begin
        next_p = p;
        next_p.rs1 = srst_i;
        next_p.rs2 = p.rs1;
        next_p.ce1 = ce_i;
        next_p.ce2 = p.ce1;
        if (p.rs2) begin
            next_p.tg1 = 1'b0;
            next_p.tg2 = 1'b0;
            next_p.tg3 = 1'b0;
            next_p.cfg = CFG_RST;
            next_p.half = 1'b0;
            next_p.pend = 1'b0;
            next_p.pipe = '0;
            next_p.st = HS_IDLE;
            next_p.wcnt = '0;
            next_p.len_cnt = '0;
            next_p.len = '0;
            next_p.mark = 1'b0;
        end else if (p.ce2) begin
            // configuration toggle crossing
            next_p.tg1 = s.req;
            next_p.tg2 = p.tg1;
            next_p.tg3 = p.tg2;
            if (p.tg2 != p.tg3) begin
                next_p.cfg = s.hold;
            end

            // two pixel clock edges per pixel period
            next_p.half = ~p.half; // RQ5
            next_p.mark = hs.lead; // RQ11

            // an edge seen mid pixel waits for the pixel boundary
            next_p.pend = p.pend | hs.lead; // RQ8

            if (!p.half) begin
                // sample enters, older words move one stage on
                next_p.pipe[0] = {sync_now, sample_i}; // RQ2
                for (int i = 1; i < LAT_PIX; i++) begin
                    next_p.pipe[i] = p.pipe[i-1]; // RQ2
                end
                // an edge seen on the boundary itself waits for the next one
                next_p.pend = hs.lead; // RQ8

                // line length in pixels, the frequency reference
                if (p.pend) begin
                    next_p.len = p.len_cnt; // RQ6
                    next_p.len_cnt = LEN_ONE;
                end else if (p.len_cnt != LEN_MAX) begin
                    next_p.len_cnt = p.len_cnt + LEN_ONE; // RQ6
                end

                // regenerated line sync pulse, width in pixels
                case (p.st)
                    HS_IDLE: begin
                        if (p.pend && p.cfg.width != '0) begin
                            next_p.st = HS_PULSE; // RQ10
                            next_p.wcnt = p.cfg.width;
                        end
                    end
                    HS_PULSE: begin
                        if (p.pend) begin
                            next_p.wcnt = p.cfg.width;
                            if (p.cfg.width == '0) begin
                                next_p.st = HS_IDLE;
                            end
                        end else if (p.wcnt <= HSW_ONE) begin
                            next_p.st = HS_IDLE;
                            next_p.wcnt = '0;
                        end else begin
                            next_p.wcnt = p.wcnt - HSW_ONE; // RQ10
                        end
                    end
                    default: begin
                        next_p.st = HS_IDLE;
                        next_p.wcnt = '0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge pix_clk_i) begin
        p <= next_p;
    end

    // ------------------------------------------------------------
    // phase shift of clock, sync and data as one bundle
    // ------------------------------------------------------------

    // clock rises half a pixel after the data changes
    assign bundle = {~p.half, p.pipe[LAT_PIX-1]}; // RQ4

    pof_shift #(
        .W(BUN_W),
        .DEPTH(DEPTH)
    ) u_shift (
        .clk_i(pix_clk_i),
        .srst_i(p.rs2),
        .ce_i(p.ce2),
        .sel_i(p.cfg.phase),
        .din_i(bundle),
        .dout_o(bundle_dly)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------

    // bit 7 of each byte lane carries the sample MSB
    assign data_o = bundle_dly[WORD_W-1:0]; // RQ1
    assign line_sync_out_o = bundle_dly[WORD_W]; // RQ3
    assign pixel_out_clock_o = bundle_dly[WORD_W+1]; // RQ4
    assign line_mark_o = p.mark;
    assign line_len_o = p.len;
endmodule
`default_nettype wire

// >>> test/pof_capture.sv
// downstream capture logic model for the pixel outputs
`timescale 1ns/1ps
`default_nettype none
module pof_capture (
    input wire logic pix_clock_i,
    input wire logic [pof_pkg::WORD_W-1:0] data_i,
    input wire logic sync_i,
    output logic [pof_pkg::WORD_W-1:0] word_o,
    output logic sync_o,
    output logic [15:0] n_cap_o
);
    import pof_pkg::*;
    initial n_cap_o = 16'h0000;
    // data and line sync strobed on the rising forwarded clock
    always @(posedge pix_clock_i) begin
        word_o <= data_i;
        sync_o <= sync_i;
        n_cap_o <= n_cap_o + 16'h0001;
    end
endmodule
`default_nettype wire

// >>> test/pof_front_assertions.sv
// concurrent checks on the pixel output front end ports
`timescale 1ns/1ps
`default_nettype none
module pof_front_chk #(
    parameter int LEN_W = 12
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic cfg_load_i,
    input wire logic cfg_busy_o,
    input wire logic pix_clk_i,
    input wire logic hsync_i,
    input wire logic [pof_pkg::WORD_W-1:0] data_o,
    input wire logic pixel_out_clock_o,
    input wire logic line_sync_out_o,
    input wire logic line_mark_o,
    input wire logic [LEN_W-1:0] line_len_o
);
    import pof_pkg::*;
    logic [3:0] quiet;
    // settle count after reset or a config load
    always_ff @(posedge pix_clk_i) begin
        if (srst_i || cfg_busy_o) begin
            quiet <= 4'h0;
        end else if (quiet != 4'hF) begin
            quiet <= quiet + 4'h1;
        end
    end
    mark_single_a: assert property (
        @(posedge pix_clk_i) disable iff (srst_i) line_mark_o |=> !line_mark_o)
        else $error("line mark wider than one cycle");
    mark_cause_a: assert property (
        @(posedge pix_clk_i) disable iff (srst_i) (quiet == 4'hF && line_mark_o)
        |-> $past(hsync_i, 1) != $past(hsync_i, 7))
        else $error("line mark without hsync edge");
    clk_toggle_a: assert property (
        @(posedge pix_clk_i) disable iff (srst_i) quiet == 4'hF
        |-> pixel_out_clock_o != $past(pixel_out_clock_o))
        else $error("forwarded clock not locked");
    data_fall_a: assert property (
        @(posedge pix_clk_i) disable iff (srst_i) (quiet == 4'hF && $changed(data_o))
        |-> $fell(pixel_out_clock_o))
        else $error("data moved off clock fall");
    sync_fall_a: assert property (
        @(posedge pix_clk_i) disable iff (srst_i)
        (quiet == 4'hF && $changed(line_sync_out_o)) |-> $fell(pixel_out_clock_o))
        else $error("line sync moved off clock fall");
    len_update_a: assert property (
        @(posedge pix_clk_i) disable iff (srst_i) (quiet == 4'hF && $changed(line_len_o))
        |-> line_mark_o || $past(line_mark_o, 1) || $past(line_mark_o, 2)
        || $past(line_mark_o, 3))
        else $error("line length changed without edge");
    busy_set_a: assert property (
        @(posedge clk_i) disable iff (srst_i) (ce_i && cfg_load_i && !cfg_busy_o)
        |=> cfg_busy_o)
        else $error("config load not taken");
    busy_clear_a: assert property (
        @(posedge clk_i) disable iff (srst_i) $rose(cfg_busy_o) |-> ##[1:60] !cfg_busy_o)
        else $error("config crossing stuck");
endmodule
bind pof_front pof_front_chk #(.LEN_W(LEN_W)) pof_front_chk_inst (
    .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .cfg_load_i(cfg_load_i),
    .cfg_busy_o(cfg_busy_o), .pix_clk_i(pix_clk_i), .hsync_i(hsync_i), .data_o(data_o),
    .pixel_out_clock_o(pixel_out_clock_o), .line_sync_out_o(line_sync_out_o),
    .line_mark_o(line_mark_o), .line_len_o(line_len_o));
`default_nettype wire

// >>> test/pof_front_bench.sv
// self-checking bench for the pixel output front end
`timescale 1ns/1ps
`default_nettype none
module pof_front_bench;
    import pof_pkg::*;
    logic clk_i, srst_i, ce_i, cfg_load_i, cfg_busy_o, pix_clk_i, hsync_i;
    logic poc, lso, mark, cs, act_pol;
    pof_cfg_t cfg_i;
    logic [WORD_W-1:0] sample_i, data_o, cw;
    logic [11:0] len;
    logic [15:0] ncap;
    logic [7:0] k = 8'h00;
    logic [7:0] k_cap;
    logic [3:0] phs [4] = '{4'h0, 4'h1, 4'h5, 4'hF};
    int n_mismatch = 0;
    int checks_done = 0;
    int mark_cnt = 0;
    int act_cnt = 0;
    pof_front pof_front_inst (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
        .cfg_load_i(cfg_load_i), .cfg_i(cfg_i), .cfg_busy_o(cfg_busy_o),
        .pix_clk_i(pix_clk_i), .sample_i(sample_i), .hsync_i(hsync_i), .data_o(data_o),
        .pixel_out_clock_o(poc), .line_sync_out_o(lso), .line_mark_o(mark),
        .line_len_o(len));
    pof_capture pof_capture_inst (.pix_clock_i(poc), .data_i(data_o), .sync_i(lso),
        .word_o(cw), .sync_o(cs), .n_cap_o(ncap));
    // clocks, link clock unrelated in phase
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    initial begin
        pix_clk_i = 1'b0;
        #7;
        forever #80 pix_clk_i = ~pix_clk_i;
    end
    // sample source and monitors
    assign sample_i = {k, ~k, k ^ 8'h1D};
    always @(negedge pix_clk_i) k <= k + 8'h01;
    always @(posedge poc) k_cap <= k;
    // sampled mid cycle, away from the launching edge
    always @(negedge pix_clk_i) begin
        mark_cnt += int'(mark === 1'b1);
        act_cnt += int'(lso === act_pol);
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic wait_busy(input logic v);
        int i;
        for (i = 0; i < 200 && cfg_busy_o !== v; i++) @(negedge clk_i);
        if (i == 200) begin
            n_mismatch++;
            end_sim();
        end
    endtask
    task automatic load(input logic hp, input logic op, input logic [7:0] w,
        input logic [3:0] ph);
        wait_busy(1'b0);
        @(negedge clk_i);
        cfg_i = '{hp, op, w, ph};
        cfg_load_i = 1'b1;
        @(negedge clk_i);
        cfg_load_i = 1'b0;
        wait_busy(1'b1);
        wait_busy(1'b0);
        repeat (16) @(negedge pix_clk_i);
    endtask
    task automatic next_cap();
        int i;
        logic [15:0] n0;
        n0 = ncap;
        for (i = 0; i < 20 && ncap === n0; i++) @(negedge pix_clk_i);
        if (i == 20) begin
            n_mismatch++;
            end_sim();
        end
    endtask
    // latency fixed, shifted by phase together with the clock
    // expected: 2 edges per pipe stage, 1 more through shift and clock rise, plus phase
    task automatic scen_phase();
        for (int j = 0; j < 4; j++) begin
            load(1'b0, 1'b1, 8'h20, phs[j]);
            next_cap();
            repeat (3) begin
                next_cap();
                check(32'(8'(k_cap - cw[23:16])), 32'(8'(2 * LAT_PIX + 1 + int'(phs[j]))));
                check(32'(cw[15:0]), 32'({~cw[23:16], cw[23:16] ^ 8'h1D}));
            end
        end
    endtask
    // leading edge only, polarity select, regenerated width
    task automatic scen_hsync(input logic hp, input logic op, input logic [7:0] w);
        load(hp, op, w, 4'h0);
        act_pol = op;
        hsync_i = ~hp;
        repeat (40) @(negedge pix_clk_i);
        mark_cnt = 0;
        act_cnt = 0;
        hsync_i = hp;
        repeat (40) @(negedge pix_clk_i);
        check(32'(mark_cnt), 32'h1);
        check(32'(act_cnt), 32'(2 * w));
        mark_cnt = 0;
        hsync_i = ~hp;
        repeat (40) @(negedge pix_clk_i);
        check(32'(mark_cnt), 32'h0);
    endtask
    // line length count from leading edges 40 pixels apart
    task automatic scen_line();
        load(1'b0, 1'b1, 8'h04, 4'h0);
        repeat (3) begin
            hsync_i = 1'b0;
            repeat (10) @(negedge pix_clk_i);
            hsync_i = 1'b1;
            repeat (70) @(negedge pix_clk_i);
        end
        check(32'(len), 32'd40);
    endtask
    // main sequence
    initial begin
        srst_i = 1'b1;
        ce_i = 1'b1;
        cfg_load_i = 1'b0;
        cfg_i = CFG_RST;
        hsync_i = 1'b1;
        act_pol = 1'b1;
        repeat (20) @(negedge clk_i);
        srst_i = 1'b0;
        scen_phase();
        scen_hsync(1'b0, 1'b1, 8'h04);
        scen_hsync(1'b1, 1'b0, 8'h03);
        scen_hsync(1'b1, 1'b1, 8'h00);
        scen_line();
        end_sim();
    end
    // overall run limit
    initial begin
        repeat (90000) @(posedge clk_i);
        n_mismatch++;
        end_sim();
    end
endmodule
`default_nettype wire
